// ### rtl/csie_pkg.sv
// Constants, field positions and carrier types for the CPU status block.
// Assumes one 200 MHz core clock and an 8-bit I/O port space.
package csie_pkg;

    // I/O port addresses
    localparam logic [7:0] ADDR_GIE = 8'h20;
    localparam logic [7:0] ADDR_PSC = 8'hFF;

    // Status and control bit positions
    localparam int PSC_RUN    = 0;
    localparam int PSC_RSVD   = 1;
    localparam int PSC_GIE    = 2;
    localparam int PSC_SUSP   = 3;
    localparam int PSC_POR    = 4;
    localparam int PSC_BUSRST = 5;
    localparam int PSC_WDR    = 6;
    localparam int PSC_PEND   = 7;

    // Per-source enable and pending positions
    localparam int SRC_BUSRST = 0;
    localparam int SRC_T128   = 1;
    localparam int SRC_T1024  = 2;
    localparam int SRC_DAC    = 4;
    localparam int SRC_GPIO   = 5;
    localparam int SRC_I2C    = 6;

    localparam logic [7:0] SRC_MASK  = 8'h77;
    localparam logic [7:0] GIE_WMASK = 8'h7F;
    localparam logic [7:0] PSC_POR_VAL = 8'h11;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // Vector numbers, lowest number wins
    localparam logic [3:0] VEC_NONE   = 4'h0;
    localparam logic [3:0] VEC_BUSRST = 4'h1;
    localparam logic [3:0] VEC_T128   = 4'h2;
    localparam logic [3:0] VEC_T1024  = 4'h3;
    localparam logic [3:0] VEC_DAC    = 4'hA;
    localparam logic [3:0] VEC_GPIO   = 4'hB;
    localparam logic [3:0] VEC_I2C    = 4'hC;

    // Timing
    localparam int CLK_NS       = 5;
    localparam int SE0_MIN_US   = 12;
    localparam int SE0_MAX_US   = 16;
    localparam int SE0_MIN_CYC  = (SE0_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int T128_US      = 128;
    localparam int T128_CYC     = T128_US * 1000 / CLK_NS;
    localparam int T1024_US     = 1024;
    localparam int T1024_DIV    = T1024_US / T128_US;
    localparam int WATCHDOG_PERIOD_MS  = 8;
    localparam int WATCHDOG_PERIOD_CYC =
        (WATCHDOG_PERIOD_MS * 1000000 + CLK_NS - 1) / CLK_NS;
    localparam int STARTUP_MS   = 96;
    localparam int STARTUP_CYC  = STARTUP_MS * 1000000 / CLK_NS;

    typedef enum logic [1:0] {
        PH_STARTUP = 2'b00,
        PH_ACTIVE  = 2'b01,
        PH_SUSPEND = 2'b10,
        PH_HALTED  = 2'b11
    } csie_phase_type;

    typedef struct packed {
        logic       io_write_instr;
        logic       io_read_instr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } csie_io_type;

    typedef struct packed {
        logic halt_instr;
        logic interrupt_disable_instr;
        logic interrupt_enable_instr;
        logic return_from_interrupt_instr;
        logic int_ack;
    } csie_instr_type;

    typedef struct packed {
        csie_phase_type phase;
        logic           rsvd1;
        logic           por;
        logic           busrst;
        logic           watchdog_restart_flag;
        logic           gie;
        logic [7:0]     en;
        logic [7:0]     pend;
        logic [15:0]    tcnt;
        logic [2:0]     tdiv;
        logic [24:0]    scnt;
        logic           wdr_done;
        logic [11:0]    se0cnt;
        logic [7:0]     gpio_prev;
        logic [7:0]     rdata;
        logic           irq_req;
        logic [3:0]     vec;
        logic           run_o;
        logic           susp_o;
    } csie_state_type;

endpackage : csie_pkg

// ### rtl/csie_pin_sync.sv
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes the pins are asynchronous to i_mclk and quasi-static per bit.
`timescale 1ns/10ps
module csie_pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_mclk,
    input  wire logic             i_resetn,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } csie_sync_type;

    csie_sync_type st_r;
    csie_sync_type st_nxt;

    always_comb begin
        st_nxt.meta = i_async;
        st_nxt.sync = st_r.meta;
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_sync = st_r.sync;

endmodule : csie_pin_sync

// ### rtl/csie_top.sv
// Processor status/control register and per-source interrupt enables.
// Assumes CPU strobes are one-cycle pulses on i_mclk; pins are async.
`timescale 1ns/10ps
module csie_top
    import csie_pkg::*;
#(
    parameter int T128_CYCLES    = T128_CYC,
    parameter int WATCH_CYCLES   = WATCHDOG_PERIOD_CYC,
    parameter int STARTUP_CYCLES = STARTUP_CYC
) (
    input  wire logic           i_mclk,
    input  wire logic           i_resetn,
    input  wire csie_io_type    i_io,
    input  wire csie_instr_type i_instr,
    input  wire logic           i_wdt_reset,
    input  wire logic           i_usb_dp,
    input  wire logic           i_usb_dm,
    input  wire logic           i_usb_activity,
    input  wire logic [7:0]     i_gpio,
    input  wire logic           i_dac_irq,
    input  wire logic           i_i2c_irq,
    output logic      [7:0]     o_io_rdata,
    output logic                o_irq_req,
    output logic      [3:0]     o_irq_vector,
    output logic                o_global_ie,
    output logic                o_run,
    output logic                o_suspend
);

    localparam csie_state_type ST_RESET = '{
        phase: PH_STARTUP,
        rsvd1: PSC_POR_VAL[PSC_RSVD],
        por: PSC_POR_VAL[PSC_POR],
        busrst: PSC_POR_VAL[PSC_BUSRST],
        watchdog_restart_flag: PSC_POR_VAL[PSC_WDR],
        gie: PSC_POR_VAL[PSC_GIE],
        en: BYTE_ZERO,
        pend: BYTE_ZERO,
        tcnt: '0,
        tdiv: '0,
        scnt: '0,
        wdr_done: 1'b0,
        se0cnt: '0,
        gpio_prev: BYTE_ZERO,
        rdata: BYTE_ZERO,
        irq_req: 1'b0,
        vec: VEC_NONE,
        run_o: 1'b0,
        susp_o: 1'b1
    };

    function automatic logic [7:0] csie_lowest(input logic [7:0] v);
        csie_lowest = v & (~v + 8'h01);
    endfunction : csie_lowest

    function automatic logic [3:0] csie_vec_of(input logic [7:0] onehot);
        logic [3:0] r;
        r = VEC_NONE;
        if (onehot[SRC_BUSRST]) r = VEC_BUSRST;
        if (onehot[SRC_T128])   r = VEC_T128;
        if (onehot[SRC_T1024])  r = VEC_T1024;
        if (onehot[SRC_DAC])    r = VEC_DAC;
        if (onehot[SRC_GPIO])   r = VEC_GPIO;
        if (onehot[SRC_I2C])    r = VEC_I2C;
        csie_vec_of = r;
    endfunction : csie_vec_of

    csie_state_type st_r;
    csie_state_type st_nxt;
    logic [10:0]    pins;
    logic [7:0]     gpio;
    logic           dp;
    logic           dm;
    logic           usb_act;
    logic           se0;
    logic           hit;
    logic           t128;
    logic           t1024;
    logic           st_wdr;
    logic           wdt_any;
    logic [7:0]     ev;
    logic [7:0]     req;
    logic [7:0]     nreq;
    logic [7:0]     pick;
    logic           psc_wr;

    csie_pin_sync #(
        .WIDTH (11)
    ) u_sync (
        .i_mclk   (i_mclk),
        .i_resetn (i_resetn),
        .i_async  ({i_usb_activity, i_usb_dm, i_usb_dp, i_gpio}),
        .o_sync   (pins)
    );

    assign gpio    = pins[7:0];
    assign dp      = pins[8];
    assign dm      = pins[9];
    assign usb_act = pins[10];

    always_comb begin
        st_nxt = st_r;
        psc_wr = i_io.io_write_instr && (i_io.addr == ADDR_PSC);
        se0 = !dp && !dm;
        hit = se0 && (st_r.se0cnt == 12'(SE0_MIN_CYC - 1));
        if (!se0) begin
            st_nxt.se0cnt = '0;
        end else if (st_r.se0cnt != 12'(SE0_MIN_CYC)) begin
            st_nxt.se0cnt = st_r.se0cnt + 12'h001;
        end
        t128  = (st_r.tcnt == 16'(T128_CYCLES - 1));
        t1024 = t128 && (st_r.tdiv == 3'(T1024_DIV - 1));
        st_nxt.tcnt = t128 ? 16'h0000 : st_r.tcnt + 16'h0001;
        if (t128) begin
            st_nxt.tdiv = st_r.tdiv + 3'h1;
        end
        st_wdr = (st_r.phase == PH_STARTUP) && !st_r.wdr_done &&
                 (st_r.scnt == 25'(WATCH_CYCLES - 1));
        if (st_r.phase == PH_STARTUP) begin
            st_nxt.scnt = st_r.scnt + 25'h0000001;
        end
        wdt_any = i_wdt_reset || st_wdr;
        ev = BYTE_ZERO;
        ev[SRC_BUSRST] = hit;
        ev[SRC_T128]   = t128;
        ev[SRC_T1024]  = t1024;
        ev[SRC_DAC]    = i_dac_irq;
        ev[SRC_GPIO]   = |(gpio ^ st_r.gpio_prev);
        ev[SRC_I2C]    = i_i2c_irq;
        ev = ev & SRC_MASK;
        st_nxt.gpio_prev = gpio;
        req  = st_r.pend & st_r.en;
        pick = i_instr.int_ack ? csie_lowest(req) : BYTE_ZERO;
        st_nxt.pend = (st_r.pend & ~pick) | ev;
        if (i_instr.interrupt_disable_instr) begin
            st_nxt.gie = 1'b0;
        end
        if (i_instr.interrupt_enable_instr ||
            i_instr.return_from_interrupt_instr) begin
            st_nxt.gie = 1'b1;
        end
        if (i_instr.int_ack) begin
            st_nxt.gie = 1'b0;
        end
        if (i_io.io_write_instr && (i_io.addr == ADDR_GIE)) begin
            st_nxt.en = i_io.wdata & GIE_WMASK;
        end
        if (psc_wr) begin
            st_nxt.rsvd1  = i_io.wdata[PSC_RSVD];
            st_nxt.por    = i_io.wdata[PSC_POR];
            st_nxt.busrst = i_io.wdata[PSC_BUSRST];
            st_nxt.watchdog_restart_flag = i_io.wdata[PSC_WDR];
            if (!i_io.wdata[PSC_RUN]) begin
                st_nxt.phase = PH_HALTED;
            end else if (i_io.wdata[PSC_SUSP] && !usb_act &&
                         st_r.phase == PH_ACTIVE) begin
                st_nxt.phase = PH_SUSPEND;
            end
        end
        case (st_r.phase)
            PH_STARTUP: begin
                if (hit || st_r.scnt == 25'(STARTUP_CYCLES - 1)) begin
                    st_nxt.phase = PH_ACTIVE;
                end
            end
            PH_SUSPEND: begin
                // wake on enabled pending or activity
                if (|req || usb_act) begin
                    st_nxt.phase = PH_ACTIVE;
                end
            end
            PH_ACTIVE: begin
                if (i_instr.halt_instr) begin
                    st_nxt.phase  = PH_HALTED;
                    st_nxt.rsvd1  = 1'b0;
                    st_nxt.por    = 1'b0;
                    st_nxt.busrst = 1'b0;
                    st_nxt.watchdog_restart_flag = 1'b0;
                    st_nxt.gie    = 1'b0;
                    st_nxt.pend   = BYTE_ZERO;
                end
            end
            PH_HALTED: st_nxt.phase = PH_HALTED;
            default:   st_nxt.phase = PH_HALTED;
        endcase
        if (hit) begin
            st_nxt.busrst = 1'b1;
        end
        if (wdt_any) begin
            st_nxt.watchdog_restart_flag = 1'b1;
            st_nxt.rsvd1  = 1'b0;
            st_nxt.gie    = 1'b0;
            st_nxt.en     = BYTE_ZERO;
            st_nxt.pend   = BYTE_ZERO;
            st_nxt.por    = st_r.por;
            st_nxt.busrst = st_r.busrst || hit;
            if (st_wdr) begin
                st_nxt.wdr_done = 1'b1;
            end
            if (st_r.phase != PH_STARTUP) begin
                st_nxt.phase = PH_ACTIVE;
            end
        end
        if (i_io.io_read_instr) begin
            if (i_io.addr == ADDR_PSC) begin
                st_nxt.rdata = {|st_r.pend, st_r.watchdog_restart_flag,
                                st_r.busrst, st_r.por,
                                st_r.phase == PH_SUSPEND ||
                                st_r.phase == PH_STARTUP,
                                st_r.gie, st_r.rsvd1,
                                st_r.phase != PH_HALTED};
            end else if (i_io.addr == ADDR_GIE) begin
                st_nxt.rdata = st_r.en;
            end else begin
                st_nxt.rdata = BYTE_ZERO;
            end
        end
        nreq = st_nxt.pend & st_nxt.en;
        st_nxt.irq_req = st_nxt.gie && (|nreq);
        st_nxt.vec = st_nxt.gie ? csie_vec_of(csie_lowest(nreq)) : VEC_NONE;
        st_nxt.run_o  = (st_nxt.phase == PH_ACTIVE);
        st_nxt.susp_o = (st_nxt.phase == PH_SUSPEND) ||
                        (st_nxt.phase == PH_STARTUP);
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_r <= ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_io_rdata   = st_r.rdata;
    assign o_irq_req    = st_r.irq_req;
    assign o_irq_vector = st_r.vec;
    assign o_global_ie  = st_r.gie;
    assign o_run        = st_r.run_o;
    assign o_suspend    = st_r.susp_o;

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_resetn);

    chk_halt_clear: assert property (
        (st_r.phase == PH_ACTIVE) && i_instr.halt_instr && !wdt_any
        |=> !st_r.gie && !st_r.por && !st_r.watchdog_restart_flag &&
            (st_r.pend == BYTE_ZERO) && !st_r.run_o
    ) else $error("halt did not clear status");

    chk_halt_stays: assert property (
        (st_r.phase == PH_HALTED) && !wdt_any
        |=> (st_r.phase == PH_HALTED)
    ) else $error("halted processor restarted");

    chk_gie_source: assert property (
        $changed(st_r.gie) |-> $past(i_instr.interrupt_disable_instr ||
            i_instr.interrupt_enable_instr || i_instr.int_ack ||
            i_instr.return_from_interrupt_instr || wdt_any ||
            i_instr.halt_instr)
    ) else $error("global enable changed without cause");

    chk_susp_refused: assert property (
        psc_wr && i_io.wdata[PSC_RUN] && i_io.wdata[PSC_SUSP] && usb_act &&
        (st_r.phase == PH_ACTIVE) && !wdt_any |=> ##1 !st_r.susp_o
    ) else $error("suspend entered during bus activity");

    chk_wake_up: assert property (
        (st_r.phase == PH_SUSPEND) && usb_act |=> ##1 st_r.run_o
    ) else $error("no wake on bus activity");

    chk_busrst_flag: assert property (
        se0 [*1] ##0 ((st_r.se0cnt == 12'(SE0_MIN_CYC - 1)) && !wdt_any &&
            !(i_instr.halt_instr && st_r.phase == PH_ACTIVE))
        |=> st_r.busrst && st_r.pend[SRC_BUSRST]
    ) else $error("bus reset flag not set");

    chk_wdr_load: assert property (
        i_wdt_reset |=> st_r.watchdog_restart_flag && !st_r.gie &&
            (st_r.en == BYTE_ZERO) && (st_r.por == $past(st_r.por))
    ) else $error("watchdog load wrong");

    chk_vec_prio: assert property (
        st_r.gie && st_r.pend[SRC_BUSRST] && st_r.en[SRC_BUSRST]
        |=> $past(st_r.irq_req) && (o_irq_vector == VEC_BUSRST ||
            $past(i_instr.int_ack || wdt_any || i_instr.halt_instr ||
            i_instr.interrupt_disable_instr))
    ) else $error("bus reset vector not first");

    chk_mask_gate: assert property (
        o_irq_req |-> |(st_r.pend & st_r.en) && st_r.gie
    ) else $error("request without enabled pending");

endmodule : csie_top

// ### tb/csie_top_tb.sv
// Self-checking bench for the CPU status and interrupt enable block.
// Assumes csie_pkg compiled first; long counts shortened by parameters.
`timescale 1ns/10ps
module csie_top_tb;
    import csie_pkg::*;

    localparam int         T128   = 50;
    localparam logic [4:0] I_HALT = 5'h10;
    localparam logic [4:0] I_DI   = 5'h08;
    localparam logic [4:0] I_EI   = 5'h04;
    localparam logic [4:0] I_RETURN_FROM_INTERRUPT_INSTR = 5'h02;
    localparam logic [4:0] I_ACK  = 5'h01;

    logic           i_mclk;
    logic           i_resetn;
    csie_io_type    i_io;
    csie_instr_type i_instr;
    logic           i_wdt_reset;
    logic           i_usb_dp;
    logic           i_usb_dm;
    logic           i_usb_activity;
    logic [7:0]     i_gpio;
    logic           i_dac_irq;
    logic           i_i2c_irq;
    logic [7:0]     o_io_rdata;
    logic           o_irq_req;
    logic [3:0]     o_irq_vector;
    logic           o_global_ie;
    logic           o_run;
    logic           o_suspend;
    int             fail_count;
    int             n_checks;
    int             cyc;
    int             t_rise;

    csie_top #(
        .T128_CYCLES    (T128),
        .WATCH_CYCLES   (200),
        .STARTUP_CYCLES (1000)
    ) dut (
        .i_mclk         (i_mclk),
        .i_resetn       (i_resetn),
        .i_io           (i_io),
        .i_instr        (i_instr),
        .i_wdt_reset    (i_wdt_reset),
        .i_usb_dp       (i_usb_dp),
        .i_usb_dm       (i_usb_dm),
        .i_usb_activity (i_usb_activity),
        .i_gpio         (i_gpio),
        .i_dac_irq      (i_dac_irq),
        .i_i2c_irq      (i_i2c_irq),
        .o_io_rdata     (o_io_rdata),
        .o_irq_req      (o_irq_req),
        .o_irq_vector   (o_irq_vector),
        .o_global_ie    (o_global_ie),
        .o_run          (o_run),
        .o_suspend      (o_suspend)
    );

    initial i_mclk = 1'h0;
    always #2.5 i_mclk = ~i_mclk;
    always @(posedge i_mclk) cyc <= cyc + 1;
    // Request rise time, for period measurement
    always @(posedge o_irq_req) t_rise = cyc;

    task automatic conclude;
        if (fail_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    task automatic check(input string name, input logic [7:0] exp,
                         input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic flag(input string name, input logic exp, input logic got);
        check(name, {7'h00, exp}, {7'h00, got});
    endtask : flag

    task automatic idle(input int n);
        repeat (n) @(negedge i_mclk);
    endtask : idle

    task automatic io(input logic wr, input logic [7:0] addr,
                      input logic [7:0] data);
        @(negedge i_mclk);
        i_io.io_write_instr = wr;
        i_io.io_read_instr  = ~wr;
        i_io.addr           = addr;
        i_io.wdata          = data;
        @(negedge i_mclk);
        i_io.io_write_instr = 1'h0;
        i_io.io_read_instr  = 1'h0;
    endtask : io

    // Pending bit of status masked where timers keep it set
    task automatic rd(input logic [7:0] addr, input logic [7:0] mask,
                      input logic [7:0] exp);
        io(1'h0, addr, 8'h00);
        check("read data", exp, o_io_rdata & mask);
    endtask : rd

    task automatic ins(input logic [4:0] v);
        @(negedge i_mclk);
        i_instr = csie_instr_type'(v);
        @(negedge i_mclk);
        i_instr = csie_instr_type'(5'h00);
    endtask : ins

    // Pulses {dac, i2c, watchdog}
    task automatic pulse(input logic [2:0] p);
        @(negedge i_mclk);
        {i_dac_irq, i_i2c_irq, i_wdt_reset} = p;
        @(negedge i_mclk);
        {i_dac_irq, i_i2c_irq, i_wdt_reset} = 3'h0;
    endtask : pulse

    task automatic irq(input logic [3:0] vec);
        flag("irq request", 1'h1, o_irq_req);
        check("irq vector", {4'h0, vec}, {4'h0, o_irq_vector});
    endtask : irq

    task automatic t_startup;
        idle(2);
        rd(ADDR_PSC, 8'hFF, 8'h19);
        rd(ADDR_GIE, 8'hFF, 8'h00);
        for (int n = 0; n < 1200 && o_run !== 1'h1; n++) idle(1);
        rd(ADDR_PSC, 8'h7F, 8'h51);
    endtask : t_startup

    task automatic t_gie;
        io(1'h1, ADDR_PSC, 8'h05);
        rd(ADDR_PSC, 8'h7F, 8'h01);
        ins(I_EI);
        flag("global enable", 1'h1, o_global_ie);
        rd(ADDR_PSC, 8'h7F, 8'h05);
        ins(I_DI);
        flag("global enable", 1'h0, o_global_ie);
        ins(I_RETURN_FROM_INTERRUPT_INSTR);
        io(1'h1, ADDR_PSC, 8'h01);
        flag("global enable", 1'h1, o_global_ie);
        ins(I_DI);
        io(1'h1, ADDR_GIE, 8'hFF);
        rd(ADDR_GIE, 8'hFF, 8'h7F);
    endtask : t_gie

    task automatic t_priority;
        io(1'h1, ADDR_GIE, 8'h50);
        ins(I_EI);
        pulse(3'h6);
        idle(1);
        irq(VEC_DAC);
        ins(I_ACK);
        flag("global enable", 1'h0, o_global_ie);
        ins(I_RETURN_FROM_INTERRUPT_INSTR);
        irq(VEC_I2C);
        ins(I_ACK);
        ins(I_RETURN_FROM_INTERRUPT_INSTR);
        flag("irq request", 1'h0, o_irq_req);
        io(1'h1, ADDR_GIE, 8'h00);
        pulse(3'h4);
        idle(2);
        flag("irq request", 1'h0, o_irq_req);
        io(1'h1, ADDR_GIE, 8'h10);
        idle(1);
        irq(VEC_DAC);
        ins(I_ACK);
    endtask : t_priority

    task automatic t_timer(input logic [7:0] en, input logic [3:0] vec,
                           input int period);
        int t1;
        io(1'h1, ADDR_GIE, en);
        ins(I_EI);
        // First rises may come from a stale flag; time the last gap
        for (int k = 0; k < 4; k++) begin
            for (int n = 0; n < period + 20 && o_irq_req !== 1'h1; n++)
                idle(1);
            irq(vec);
            if (k == 3) begin
                check("timer period", period[7:0], 8'(t_rise - t1));
            end
            t1 = t_rise;
            ins(I_ACK);
            ins(I_RETURN_FROM_INTERRUPT_INSTR);
        end
    endtask : t_timer

    task automatic t_gpio;
        io(1'h1, ADDR_GIE, 8'h20);
        @(negedge i_mclk) i_gpio = 8'h08;
        idle(5);
        irq(VEC_GPIO);
        ins(I_ACK);
        ins(I_RETURN_FROM_INTERRUPT_INSTR);
        @(negedge i_mclk) i_gpio = 8'h00;
        idle(5);
        irq(VEC_GPIO);
        ins(I_ACK);
    endtask : t_gpio

    task automatic t_suspend;
        io(1'h1, ADDR_GIE, 8'h10);
        @(negedge i_mclk) i_usb_activity = 1'h1;
        idle(4);
        io(1'h1, ADDR_PSC, 8'h09);
        idle(3);
        flag("suspend", 1'h0, o_suspend);
        @(negedge i_mclk) i_usb_activity = 1'h0;
        idle(4);
        io(1'h1, ADDR_PSC, 8'h09);
        idle(3);
        flag("suspend", 1'h1, o_suspend);
        flag("run", 1'h0, o_run);
        @(negedge i_mclk) i_usb_activity = 1'h1;
        idle(6);
        flag("suspend", 1'h0, o_suspend);
        flag("run", 1'h1, o_run);
        @(negedge i_mclk) i_usb_activity = 1'h0;
        idle(4);
        io(1'h1, ADDR_PSC, 8'h09);
        idle(3);
        flag("suspend", 1'h1, o_suspend);
        pulse(3'h4);
        idle(5);
        flag("suspend", 1'h0, o_suspend);
        ins(I_ACK);
    endtask : t_suspend

    task automatic t_halt;
        ins(I_HALT);
        idle(2);
        flag("run", 1'h0, o_run);
        rd(ADDR_PSC, 8'h7F, 8'h00);
        ins(I_EI);
        idle(20);
        flag("run", 1'h0, o_run);
        pulse(3'h1);
        idle(3);
        flag("run", 1'h1, o_run);
        rd(ADDR_PSC, 8'h7F, 8'h41);
    endtask : t_halt

    task automatic t_busreset;
        io(1'h1, ADDR_GIE, 8'h01);
        ins(I_EI);
        @(negedge i_mclk) i_usb_dp = 1'h0;
        idle(2300);
        flag("irq request", 1'h0, o_irq_req);
        idle(200);
        irq(VEC_BUSRST);
        @(negedge i_mclk) i_usb_dp = 1'h1;
        ins(I_ACK);
        rd(ADDR_PSC, 8'h7F, 8'h61);
        io(1'h1, ADDR_PSC, 8'h31);
        ins(I_EI);
        pulse(3'h1);
        idle(2);
        rd(ADDR_PSC, 8'h7F, 8'h71);
        rd(ADDR_GIE, 8'hFF, 8'h00);
        flag("global enable", 1'h0, o_global_ie);
    endtask : t_busreset

    initial begin
        i_resetn       = 1'h0;
        i_io           = csie_io_type'(18'h00000);
        i_instr        = csie_instr_type'(5'h00);
        i_wdt_reset    = 1'h0;
        i_usb_dp       = 1'h1;
        i_usb_dm       = 1'h0;
        i_usb_activity = 1'h0;
        i_gpio         = 8'h00;
        i_dac_irq      = 1'h0;
        i_i2c_irq      = 1'h0;
        fail_count     = 0;
        n_checks       = 0;
        cyc            = 0;
        t_rise         = 0;
        repeat (5) @(posedge i_mclk);
        @(negedge i_mclk) i_resetn = 1'h1;
        t_startup;
        t_gie;
        t_priority;
        t_timer(8'h02, VEC_T128, T128);
        t_timer(8'h04, VEC_T1024, T128 * 8);
        t_gpio;
        t_suspend;
        t_halt;
        t_busreset;
        conclude;
    end

    // Cuts a hang well past the expected run length
    initial begin
        #(60000 * 5);
        fail_count++;
        conclude;
    end

endmodule : csie_top_tb
